//--- rtl/uif_cfg.svh
// Purpose: offsets, field positions, reset values of the serial port interrupt front end
// Assumes: byte addresses on a 32-bit word register port
// Notes:   definitions only
`ifndef UIF_CFG_SVH
`define UIF_CFG_SVH
`define UIF_OFF_THRESH      12'h034
`define UIF_OFF_MASK        12'h038
`define UIF_OFF_RAW         12'h03c
`define UIF_OFF_MASKED      12'h040
`define UIF_OFF_CLEAR       12'h044
`define UIF_TX_SEL_LSB      0
`define UIF_RX_SEL_LSB      3
`define UIF_SEL_W           3
`define UIF_NSRC            11
`define UIF_SEL_RST         3'h2
`define UIF_MASK_RST        11'h000
`define UIF_RAW_RST         7'h00
`define UIF_BIT_RX          4
`define UIF_BIT_TX          5
`define UIF_BIT_MODEM_TOP   3
`endif

//--- rtl/uif_pkg.sv
// Purpose: types shared by the interrupt front end
// Assumes: eleven sources, bit 10 overrun down to bit 0 ring indicator
// Notes:   field order of the struct follows the status bit order
package uif_pkg;
	typedef struct packed {
		logic overrun_irq;
		logic break_irq;
		logic parity_irq;
		logic framing_irq;
		logic rx_timeout_irq;
		logic tx_level_irq;
		logic rx_level_irq;
		logic dataset_ready_irq;
		logic carrier_detect_irq;
		logic clear_to_send_irq;
		logic ring_indicator_irq;
	} uif_src_t;
	typedef struct packed {
		logic [2:0] rx_threshold_sel;
		logic [2:0] tx_threshold_sel;
	} uif_thresh_t;
endpackage

//--- rtl/uif_level_cmp.sv
// Purpose: turn a fill level and a threshold code into a trigger condition
// Assumes: level counts entries, 0..DEPTH
// Notes:   reserved codes never trigger
`timescale 1ns/10ps
`include "uif_cfg.svh"
module uif_level_cmp #(
	parameter int DEPTH = 32,
	parameter int LW    = 6,
	parameter bit IS_RX = 1'b1
) (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire logic [LW-1:0]         level,
	input  wire logic [`UIF_SEL_W-1:0] sel,
	output logic                       hit
);
	logic [LW+2:0] lvl8;
	logic [LW+2:0] lim;
	logic          next_hit;

	// compare level*8 against depth*eighths to avoid division
	always_comb
	begin
		lvl8 = {level, 3'h0};
		lim  = '0;
		next_hit = 1'b0;
		case (sel)
			3'h0: lim = (LW+3)'(IS_RX ? DEPTH : DEPTH);
			3'h1: lim = (LW+3)'(IS_RX ? DEPTH * 4 : DEPTH * 2);
			3'h2: lim = (LW+3)'(DEPTH * 4);
			3'h3: lim = (LW+3)'(DEPTH * 6);
			3'h4: lim = (LW+3)'(DEPTH * 7);
			default: lim = '0;
		endcase
		if (sel <= 3'h4)
			next_hit = IS_RX ? (lvl8 >= lim) : (lvl8 <= lim);
	end

	// registered so the status path sees a clean level
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			hit <= 1'b0;
		else
			hit <= next_hit;
	end
endmodule // uif_level_cmp

//--- rtl/uif_irq_front.sv
// Purpose: interrupt front end of a serial port: thresholds, mask, raw/masked status
// Assumes: fifo levels and event strobes come from logic on ref_clk; modem pins are async
// Notes:   register port returns read data one cycle after the read strobe
//
// What this block does
// - 3-bit receive threshold at bits 5:3, eighths/halves/3-4/7-8, reset 2.
// - 3-bit transmit threshold at bits 2:0, 1/8 to 7/8, reset 2.
// - receive fires at or above level; transmit fires at or below.
// - mask has one enable per source, bit 10 overrun down to bit 0 ring.
// - writing 1 sets an enable, writing 0 clears it.
// - mask reads back stored enables; all reset to zero.
// - raw status is read-only, same bit layout, ignores the mask.
// - all raw bits reset to zero, modem ones too; modem bits set on a line change.
// - masked status is raw status gated by mask, else zero.
// - writing 1 to clear register bit clears that pending source.
`timescale 1ns/10ps
`include "uif_cfg.svh"
module uif_irq_front #(
	parameter int RX_DEPTH = 32,
	parameter int TX_DEPTH = 32,
	parameter int LW       = 6
) (
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire logic [11:0]   addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [31:0]   rdata,
	input  wire logic [LW-1:0] rx_level,
	input  wire logic [LW-1:0] tx_level,
	input  wire logic          overrun_evt,
	input  wire logic          break_evt,
	input  wire logic          parity_evt,
	input  wire logic          framing_evt,
	input  wire logic          rx_timeout_evt,
	input  wire logic          dataset_ready_n,
	input  wire logic          carrier_detect_n,
	input  wire logic          clear_to_send_n,
	input  wire logic          ring_indicator_n,
	output logic               irq
);
	uif_pkg::uif_thresh_t thresh;
	uif_pkg::uif_thresh_t next_thresh;
	uif_pkg::uif_src_t    mask;
	uif_pkg::uif_src_t    next_mask;
	uif_pkg::uif_src_t    raw;
	uif_pkg::uif_src_t    next_raw;
	uif_pkg::uif_src_t    masked;
	logic [3:0]           modem_s1;
	logic [3:0]           modem_s2;
	logic [3:0]           modem_d;
	logic                 rx_hit;
	logic                 tx_hit;
	logic                 rx_hit_d;
	logic                 tx_hit_d;
	logic [31:0]          next_rdata;
	logic                 next_irq;
	logic [`UIF_NSRC-1:0] set_vec;
	logic [`UIF_NSRC-1:0] clr_vec;
	logic                 wr_thresh;
	logic                 wr_mask;
	logic                 wr_clear;

	// threshold comparators, one per direction
	uif_level_cmp #(.DEPTH(RX_DEPTH), .LW(LW), .IS_RX(1'b1)) u_rx_cmp (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.level   (rx_level),
		.sel     (thresh.rx_threshold_sel),
		.hit     (rx_hit)
	);
	uif_level_cmp #(.DEPTH(TX_DEPTH), .LW(LW), .IS_RX(1'b0)) u_tx_cmp (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.level   (tx_level),
		.sel     (thresh.tx_threshold_sel),
		.hit     (tx_hit)
	);

	// address decode of writes
	always_comb
	begin
		wr_thresh = wr && (addr == `UIF_OFF_THRESH);
		wr_mask   = wr && (addr == `UIF_OFF_MASK);
		wr_clear  = wr && (addr == `UIF_OFF_CLEAR);
	end

	// control registers; upper data bits simply are not stored
	always_comb
	begin
		next_thresh = thresh;
		next_mask   = mask;
		if (wr_thresh)
			next_thresh = uif_pkg::uif_thresh_t'(wdata[5:0]);
		if (wr_mask)
			next_mask = uif_pkg::uif_src_t'(wdata[`UIF_NSRC-1:0]);
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			thresh <= uif_pkg::uif_thresh_t'({`UIF_SEL_RST, `UIF_SEL_RST});
			mask   <= uif_pkg::uif_src_t'(`UIF_MASK_RST);
		end
		else
		begin
			thresh <= next_thresh;
			mask   <= next_mask;
		end
	end

	// modem pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// low-active pins idle high; a zero reset would fake a change after release
			modem_s1 <= 4'hf;
			modem_s2 <= 4'hf;
			modem_d  <= 4'hf;
		end
		else
		begin
			modem_s1 <= {dataset_ready_n, carrier_detect_n, clear_to_send_n, ring_indicator_n};
			modem_s2 <= modem_s1;
			modem_d  <= modem_s2;
		end
	end

	// event sources: error strobes, fifo level rising edges, modem line changes
	always_comb
	begin
		set_vec = {overrun_evt, break_evt, parity_evt, framing_evt, rx_timeout_evt,
			tx_hit & ~tx_hit_d, rx_hit & ~rx_hit_d, modem_s2 ^ modem_d};
		clr_vec = wr_clear ? wdata[`UIF_NSRC-1:0] : '0;
		// a set arriving with its clear wins so no event is lost
		next_raw = uif_pkg::uif_src_t'(set_vec | (raw & ~clr_vec));
	end

	// raw status; modem bits share the zero reset, which the outside may not rely on
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			raw      <= uif_pkg::uif_src_t'(`UIF_MASK_RST);
			rx_hit_d <= 1'b0;
			tx_hit_d <= 1'b0;
		end
		else
		begin
			raw      <= next_raw;
			rx_hit_d <= rx_hit;
			tx_hit_d <= tx_hit;
		end
	end

	// masked view and the combined interrupt
	always_comb
	begin
		masked   = raw & mask;
		next_irq = |next_raw & |(next_raw & next_mask);
		next_rdata = 32'h0000_0000;
		if (rd)
		begin
			case (addr)
				`UIF_OFF_THRESH: next_rdata = {26'h0, thresh};
				`UIF_OFF_MASK:   next_rdata = {21'h0, mask};
				`UIF_OFF_RAW:    next_rdata = {21'h0, raw};
				`UIF_OFF_MASKED: next_rdata = {21'h0, masked};
				default:         next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata <= 32'h0000_0000;
			irq   <= 1'b0;
		end
		else
		begin
			rdata <= next_rdata;
			irq   <= next_irq;
		end
	end
endmodule // uif_irq_front

//--- verification/uif_irq_chk.sv
// Purpose: port checks of the interrupt front end
// Assumes: read data stands only in the cycle after rd
// Notes:   bound to uif_irq_front by the bind below
`timescale 1ns/10ps
module uif_irq_chk (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        overrun_evt,
	input wire logic        irq
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_idle; !$past(rd) |-> rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_resv; rd |=> rdata[31:11] == 21'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_mask; wr && addr == 12'h038 ##1 !wr ##1 rd && addr == 12'h038
		|=> rdata == {21'h0, $past(wdata[10:0], 3)}; endproperty
	a_mask: assert property (p_mask) else $error("enable readback");
	property p_thr; wr && addr == 12'h034 ##1 !wr ##1 rd && addr == 12'h034
		|=> rdata == {26'h0, $past(wdata[5:0], 3)}; endproperty
	a_thr: assert property (p_thr) else $error("threshold readback");
	property p_evt; overrun_evt ##2 rd && addr == 12'h03c |=> rdata[10]; endproperty
	a_evt: assert property (p_evt) else $error("overrun not pending");
	property p_clr; rd && addr == 12'h044 |=> rdata == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear reg not zero");
	property p_unmap; rd && addr == 12'h100 |=> rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	// irq and the masked view describe the same cycle
	property p_irq; rd && addr == 12'h040 && !wr |=> (rdata != 32'h0) == $past(irq); endproperty
	a_irq: assert property (p_irq) else $error("irq and masked differ");
endmodule // uif_irq_chk
bind uif_irq_front uif_irq_chk uif_irq_chk_inst (.ref_clk, .resetn, .addr, .wdata, .wr, .rd,
	.rdata, .overrun_evt, .irq);

//--- verification/uif_cpu_model.sv
// Purpose: processor on the register port
// Assumes: one-cycle strobes, never both at once
// Notes:   tasks are called by the bench
`timescale 1ns/10ps
module uif_cpu_model (
	input wire logic [31:0] rdata,
	input wire logic        ref_clk,
	output logic     [11:0] addr,
	output logic     [31:0] wdata,
	output logic            wr,
	output logic            rd
);
	// quiet port from time zero
	initial {addr, wdata, wr, rd} = '0;
	// strobe drops on the next edge, so a following call starts one edge later
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// data taken at the edge closing the cycle in which they stand
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(posedge ref_clk);
		d = rdata;
	endtask
endmodule // uif_cpu_model

//--- verification/tb_top.sv
// Purpose: self-checking bench of the interrupt front end
// Assumes: default depth 32, level width 6
// Notes:   threshold rows first, then reset and status cases
`timescale 1ns/10ps
module tb_top;
	logic        ref_clk, resetn, wr, rd, irq;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [5:0]  rx_level, tx_level;
	logic [4:0]  evt;
	logic [3:0]  modem_n;
	int          fails, checks, cyc;
	// code, rx level, tx level, expected tx/rx raw bits; edges of each code, then reserved
	logic [16:0] rows [11] = '{17'h00413, 17'h00314, 17'h05023, 17'h04f24, 17'h09043,
		17'h08f44, 17'h0d863, 17'h0d764, 17'h11c73, 17'h11b74, 17'h16000};
	uif_irq_front uif_irq_front_inst (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
		.rx_level, .tx_level, .overrun_evt(evt[4]), .break_evt(evt[3]), .parity_evt(evt[2]),
		.framing_evt(evt[1]), .rx_timeout_evt(evt[0]), .dataset_ready_n(modem_n[3]),
		.carrier_detect_n(modem_n[2]), .clear_to_send_n(modem_n[1]),
		.ring_indicator_n(modem_n[0]), .irq);
	uif_cpu_model uif_cpu_model_inst (.ref_clk, .rdata, .addr, .wdata, .wr, .rd);
	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// a hang costs a mismatch and ends the run
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		uif_cpu_model_inst.rd_reg(a, v);
		check(v, e);
	endtask
	task automatic wc(input logic [11:0] a, input logic [31:0] d);
		uif_cpu_model_inst.wr_reg(a, d);
	endtask
	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// idle levels hit no code: rx empty, tx full
	initial
	begin
		{resetn, rx_level, evt} = '0;
		tx_level = 6'h20;
		modem_n  = 4'hf;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[i])
		begin
			wc(12'h034, {26'h0, rows[i][16:14], rows[i][16:14]});
			wc(12'h044, 32'h30);
			rx_level <= rows[i][13:8];
			tx_level <= rows[i][7:2];
			repeat (4) @(posedge ref_clk);
			uif_cpu_model_inst.rd_reg(12'h03c, v);
			check({30'h0, v[5:4]}, {30'h0, rows[i][1:0]});
			rx_level <= 6'h0;
			tx_level <= 6'h20;
		end
		$display("threshold rows done");
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(posedge ref_clk);
		resetn <= 1'b1;
		rc(12'h034, 32'h12);
		rc(12'h038, 32'h0);
		rc(12'h03c, 32'h0);
		wc(12'h038, 32'hffffffff);
		rc(12'h038, 32'h7ff);
		wc(12'h038, 32'h0);
		rc(12'h038, 32'h0);
		wc(12'h034, 32'hffffffe3);
		rc(12'h034, 32'h23);
		// every error event in one cycle, modem lines changed together
		@(posedge ref_clk);
		evt     <= 5'h1f;
		modem_n <= 4'h0;
		@(posedge ref_clk);
		evt <= 5'h0;
		uif_cpu_model_inst.rd_reg(12'h03c, v);
		check({27'h0, v[10:6]}, 32'h1f);
		repeat (6) @(posedge ref_clk);
		rc(12'h03c, 32'h7cf);
		rc(12'h040, 32'h0);
		check({31'h0, irq}, 32'h0);
		wc(12'h038, 32'h41);
		rc(12'h040, 32'h41);
		check({31'h0, irq}, 32'h1);
		wc(12'h044, 32'h40);
		rc(12'h03c, 32'h78f);
		wc(12'h044, 32'h1);
		rc(12'h040, 32'h0);
		check({31'h0, irq}, 32'h0);
		wc(12'h03c, 32'h0);
		rc(12'h03c, 32'h78e);
		rc(12'h044, 32'h0);
		rc(12'h100, 32'h0);
		$display("status cases done");
		test_done();
	end
endmodule // tb_top
